// file: inc/rps_defines.vh
// constants of the remappable pin select block
`ifndef RPS_DEFINES_VH
`define RPS_DEFINES_VH

// ----------------------------------------
// field sizes and counts
// ----------------------------------------
`define RPS_SEL_W        5
`define RPS_MAX_PINS     26
`define RPS_NUM_INPUTS   30

// ----------------------------------------
// reset values
// ----------------------------------------
`define RPS_IN_SEL_RST   5'h1f
`define RPS_OUT_SEL_RST  5'h00
`define RPS_IN_TIED_LOW  5'h1f

// ----------------------------------------
// input selector indices, bit positions of periph_in
// ----------------------------------------
`define RPS_IN_EXT_IRQ1   5'd0
`define RPS_IN_EXT_IRQ2   5'd1
`define RPS_IN_TMR2_CLK   5'd2
`define RPS_IN_TMR3_CLK   5'd3
`define RPS_IN_TMR4_CLK   5'd4
`define RPS_IN_TMR5_CLK   5'd5
`define RPS_IN_CAPT1      5'd6
`define RPS_IN_CAPT2      5'd7
`define RPS_IN_CAPT7      5'd8
`define RPS_IN_CAPT8      5'd9
`define RPS_IN_CMP_FAULT  5'd10
`define RPS_IN_PWM1_FAULT 5'd11
`define RPS_IN_PWM2_FAULT 5'd12
`define RPS_IN_DEC1_A     5'd13
`define RPS_IN_DEC1_B     5'd14
`define RPS_IN_DEC1_IDX   5'd15
`define RPS_IN_DEC2_A     5'd16
`define RPS_IN_DEC2_B     5'd17
`define RPS_IN_DEC2_IDX   5'd18
`define RPS_IN_UART1_RX   5'd19
`define RPS_IN_UART1_CTS  5'd20
`define RPS_IN_UART2_RX   5'd21
`define RPS_IN_UART2_CTS  5'd22
`define RPS_IN_SPI1_DIN   5'd23
`define RPS_IN_SPI1_CLK   5'd24
`define RPS_IN_SPI1_SEL   5'd25
`define RPS_IN_SPI2_DIN   5'd26
`define RPS_IN_SPI2_CLK   5'd27
`define RPS_IN_SPI2_SEL   5'd28
`define RPS_IN_CAN_RX     5'd29

// ----------------------------------------
// output selection codes
// ----------------------------------------
`define RPS_OUT_NULL      5'h00
`define RPS_OUT_CMP1      5'h01
`define RPS_OUT_CMP2      5'h02
`define RPS_OUT_U1_TX     5'h03
`define RPS_OUT_U1_RTS    5'h04
`define RPS_OUT_U2_TX     5'h05
`define RPS_OUT_U2_RTS    5'h06
`define RPS_OUT_SPI1_DOUT 5'h07
`define RPS_OUT_SPI1_CLK  5'h08
`define RPS_OUT_SPI1_SEL  5'h09
`define RPS_OUT_SPI2_DOUT 5'h0a
`define RPS_OUT_SPI2_CLK  5'h0b
`define RPS_OUT_SPI2_SEL  5'h0c
`define RPS_OUT_CAN_TX    5'h10
`define RPS_OUT_OC1       5'h12
`define RPS_OUT_OC2       5'h13
`define RPS_OUT_OC3       5'h14
`define RPS_OUT_OC4       5'h15
`define RPS_OUT_DEC1_DIR  5'h1a
`define RPS_OUT_DEC2_DIR  5'h1b

`endif

// file: core/rps_in_mux.v
// one peripheral input selector: picks a pin, or ties low
`timescale 1ns/100ps
`include "rps_defines.vh"

module rps_in_mux
#(
	parameter NPINS = `RPS_MAX_PINS
)
(
	// clock and reset
	input  wire                  sys_clk,
	input  wire                  rst,
	// selection and pins
	input  wire [4:0]            sel,
	input  wire [NPINS-1:0]      pins,
	// routed value
	output reg                   routed_r
);

	reg routed_nxt;

	always @*
	begin
		routed_nxt = 1'b0;
		if (sel == `RPS_IN_TIED_LOW)
			routed_nxt = 1'b0;
		else if ({27'd0, sel} < NPINS)
			routed_nxt = pins[sel];
	end

	always @(posedge sys_clk)
	begin
		if (rst)
			routed_r <= 1'b0;
		else
			routed_r <= routed_nxt;
	end

endmodule

// file: core/rps_top.v
// remappable pin select: input and output routing between peripherals and pins
`timescale 1ns/100ps
`include "rps_defines.vh"

module rps_top
#(
	parameter NPINS = `RPS_MAX_PINS
)
(
	// clock and reset
	input  wire                  sys_clk,
	input  wire                  rst,
	// selector configuration port
	input  wire                  map_write_lock,
	input  wire                  cfg_wr_en,
	input  wire                  cfg_wr_out,
	input  wire [4:0]            cfg_wr_idx,
	input  wire [4:0]            cfg_wr_data,
	input  wire                  cfg_rd_out,
	input  wire [4:0]            cfg_rd_idx,
	output reg  [4:0]            cfg_rd_data_r,
	output reg                   cfg_wr_done_r,
	output reg                   cfg_wr_taken_r,
	// remappable pins
	input  wire [NPINS-1:0]      rp_pin_in,
	output reg  [NPINS-1:0]      rp_pin_out_r,
	output reg  [NPINS-1:0]      rp_pin_oe_r,
	// ordinary port drive for each pin
	input  wire [NPINS-1:0]      port_out,
	input  wire [NPINS-1:0]      port_oe,
	// peripheral outputs
	input  wire                  comparator_one_out,
	input  wire                  comparator_two_out,
	input  wire                  uart_one_tx_out,
	input  wire                  uart_one_rts_out,
	input  wire                  uart_two_tx_out,
	input  wire                  uart_two_rts_out,
	input  wire                  spi_one_dout,
	input  wire                  spi_one_clk_out,
	input  wire                  spi_one_sel_out,
	input  wire                  spi_two_dout,
	input  wire                  spi_two_clk_out,
	input  wire                  spi_two_sel_out,
	input  wire                  can_tx_out,
	input  wire [3:0]            compare_out,
	input  wire                  decoder_one_direction,
	input  wire                  decoder_two_direction,
	// peripheral inputs, indexed by input selector number
	output wire [`RPS_NUM_INPUTS-1:0] periph_in
);

	localparam NIN = `RPS_NUM_INPUTS;

	// ----------------------------------------
	// selector storage, two separate groups
	// ----------------------------------------
	reg [4:0] input_route_regs  [0:NIN-1];
	reg [4:0] output_route_regs [0:NPINS-1];

	// ----------------------------------------
	// pin input synchroniser
	// ----------------------------------------
	reg [NPINS-1:0] pin_meta_r;
	reg [NPINS-1:0] pin_sync_r;

	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			pin_meta_r <= {NPINS{1'b0}};
			pin_sync_r <= {NPINS{1'b0}};
		end
		else
		begin
			pin_meta_r <= rp_pin_in;
			pin_sync_r <= pin_meta_r;
		end
	end

	// ----------------------------------------
	// write acceptance
	// ----------------------------------------
	wire in_val_ok  = (cfg_wr_data == `RPS_IN_TIED_LOW) ||
	                  ({27'd0, cfg_wr_data} < NPINS);
	wire in_wr_ok   = !cfg_wr_out && ({27'd0, cfg_wr_idx} < NIN) && in_val_ok;
	wire out_wr_ok  = cfg_wr_out && ({27'd0, cfg_wr_idx} < NPINS);
	wire wr_allowed = cfg_wr_en && !map_write_lock;

	integer i;

	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			for (i = 0; i < NIN; i = i + 1)
				input_route_regs[i] <= `RPS_IN_SEL_RST;
			for (i = 0; i < NPINS; i = i + 1)
				output_route_regs[i] <= `RPS_OUT_SEL_RST;
		end
		else if (wr_allowed)
		begin
			if (in_wr_ok)
				input_route_regs[cfg_wr_idx] <= cfg_wr_data;
			else if (out_wr_ok)
				output_route_regs[cfg_wr_idx] <= cfg_wr_data;
		end
	end

	// locked writes still complete; taken shows whether the write was stored
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			cfg_wr_done_r  <= 1'b0;
			cfg_wr_taken_r <= 1'b0;
		end
		else
		begin
			cfg_wr_done_r  <= cfg_wr_en;
			cfg_wr_taken_r <= wr_allowed && (in_wr_ok || out_wr_ok);
		end
	end

	// ----------------------------------------
	// readback
	// ----------------------------------------
	reg [4:0] rd_nxt;

	always @*
	begin
		rd_nxt = 5'h00;
		if (!cfg_rd_out && ({27'd0, cfg_rd_idx} < NIN))
			rd_nxt = input_route_regs[cfg_rd_idx];
		else if (cfg_rd_out && ({27'd0, cfg_rd_idx} < NPINS))
			rd_nxt = output_route_regs[cfg_rd_idx];
	end

	always @(posedge sys_clk)
	begin
		if (rst)
			cfg_rd_data_r <= 5'h00;
		else
			cfg_rd_data_r <= rd_nxt;
	end

	// ----------------------------------------
	// input routing, one selector per peripheral input
	// ----------------------------------------
	genvar g;

	generate
		for (g = 0; g < NIN; g = g + 1)
		begin : in_route
			// every selector reads the same pin vector, so sharing is free
			rps_in_mux #(
				.NPINS    (NPINS)
			) u_mux (
				.sys_clk  (sys_clk),
				.rst      (rst),
				.sel      (input_route_regs[g]),
				.pins     (pin_sync_r),
				.routed_r (periph_in[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// output routing, one code per pin
	// ----------------------------------------
	// level of every peripheral output, bit n answers output code n;
	// passed in as an argument so the pin logic wakes on every source change
	wire [31:0] src_lvl = {4'h0, decoder_two_direction, decoder_one_direction, 4'h0,
	                       compare_out, 1'b0, can_tx_out, 3'h0,
	                       spi_two_sel_out, spi_two_clk_out, spi_two_dout,
	                       spi_one_sel_out, spi_one_clk_out, spi_one_dout,
	                       uart_two_rts_out, uart_two_tx_out,
	                       uart_one_rts_out, uart_one_tx_out,
	                       comparator_two_out, comparator_one_out, 1'b0};

	// returns {drive, level}; drive low leaves the port in charge
	function [1:0] out_src;
		input [4:0]  code;
		input [31:0] lvl;
		begin
			case (code)
				`RPS_OUT_CMP1:      out_src = {1'b1, lvl[code]};
				`RPS_OUT_CMP2:      out_src = {1'b1, lvl[code]};
				`RPS_OUT_U1_TX:     out_src = {1'b1, lvl[code]};
				`RPS_OUT_U1_RTS:    out_src = {1'b1, lvl[code]};
				`RPS_OUT_U2_TX:     out_src = {1'b1, lvl[code]};
				`RPS_OUT_U2_RTS:    out_src = {1'b1, lvl[code]};
				`RPS_OUT_SPI1_DOUT: out_src = {1'b1, lvl[code]};
				`RPS_OUT_SPI1_CLK:  out_src = {1'b1, lvl[code]};
				`RPS_OUT_SPI1_SEL:  out_src = {1'b1, lvl[code]};
				`RPS_OUT_SPI2_DOUT: out_src = {1'b1, lvl[code]};
				`RPS_OUT_SPI2_CLK:  out_src = {1'b1, lvl[code]};
				`RPS_OUT_SPI2_SEL:  out_src = {1'b1, lvl[code]};
				`RPS_OUT_CAN_TX:    out_src = {1'b1, lvl[code]};
				`RPS_OUT_OC1:       out_src = {1'b1, lvl[code]};
				`RPS_OUT_OC2:       out_src = {1'b1, lvl[code]};
				`RPS_OUT_OC3:       out_src = {1'b1, lvl[code]};
				`RPS_OUT_OC4:       out_src = {1'b1, lvl[code]};
				`RPS_OUT_DEC1_DIR:  out_src = {1'b1, lvl[code]};
				`RPS_OUT_DEC2_DIR:  out_src = {1'b1, lvl[code]};
				default:            out_src = 2'b00;
			endcase
		end
	endfunction

	reg [NPINS-1:0] pin_out_nxt;
	reg [NPINS-1:0] pin_oe_nxt;
	reg [1:0]       src;
	integer         p;

	always @*
	begin
		src         = 2'b00;
		pin_out_nxt = port_out;
		pin_oe_nxt  = port_oe;
		for (p = 0; p < NPINS; p = p + 1)
		begin
			src = out_src(output_route_regs[p], src_lvl);
			if (src[1])
			begin
				pin_out_nxt[p] = src[0];
				pin_oe_nxt[p]  = 1'b1;
			end
		end
	end

	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			rp_pin_out_r <= {NPINS{1'b0}};
			rp_pin_oe_r  <= {NPINS{1'b0}};
		end
		else
		begin
			rp_pin_out_r <= pin_out_nxt;
			rp_pin_oe_r  <= pin_oe_nxt;
		end
	end

endmodule

// file: bench/rps_top_assertions.sv
// concurrent checks on the remappable pin select top ports
`timescale 1ns/100ps
`include "rps_defines.vh"

module rps_top_assertions
#(
	parameter NPINS = 26
)
(
	// clock and reset
	input wire                       sys_clk,
	input wire                       rst,
	// configuration port
	input wire                       map_write_lock,
	input wire                       cfg_wr_en,
	input wire                       cfg_wr_out,
	input wire [4:0]                 cfg_wr_idx,
	input wire [4:0]                 cfg_wr_data,
	input wire                       cfg_wr_done_r,
	input wire                       cfg_wr_taken_r,
	// pins and sources
	input wire [NPINS-1:0]           rp_pin_out_r,
	input wire [NPINS-1:0]           rp_pin_oe_r,
	input wire [NPINS-1:0]           port_out,
	input wire [NPINS-1:0]           port_oe,
	input wire                       comparator_one_out,
	input wire [`RPS_NUM_INPUTS-1:0] periph_in
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire wr_ok = cfg_wr_en && !map_write_lock;
	wire o3    = wr_ok && cfg_wr_out && cfg_wr_idx == 5'h03;
	wire in_ok = wr_ok && !cfg_wr_out && cfg_wr_idx < 5'd30;

	AST_WR_DONE: assert property (cfg_wr_en |=> cfg_wr_done_r)
		else $error("write not acknowledged");
	AST_WR_LOCKED: assert property (cfg_wr_en && map_write_lock |=> !cfg_wr_taken_r)
		else $error("locked write changed storage");
	AST_IN_BADVAL: assert property (in_ok && cfg_wr_data >= NPINS && cfg_wr_data != 5'h1f
		|=> !cfg_wr_taken_r) else $error("out of range input value stored");
	AST_OUT_BADPIN: assert property (wr_ok && cfg_wr_out && cfg_wr_idx >= NPINS
		|=> !cfg_wr_taken_r) else $error("write to missing pin stored");
	AST_IN_GOOD: assert property (in_ok && cfg_wr_data < NPINS |=> cfg_wr_taken_r)
		else $error("valid input selection not stored");
	AST_CMP1: assert property (o3 && cfg_wr_data == 5'h01 |-> ##3 rp_pin_oe_r[3] &&
		rp_pin_out_r[3] == $past(comparator_one_out)) else $error("comparator not on pin");
	AST_NULL: assert property (o3 && (cfg_wr_data == 5'h00 || cfg_wr_data == 5'h0d)
		|-> ##3 rp_pin_oe_r[3] == $past(port_oe[3]) && rp_pin_out_r[3] == $past(port_out[3]))
		else $error("null code did not give port control");
	AST_TIE_LOW: assert property (in_ok && cfg_wr_idx == 5'd19 && cfg_wr_data == 5'h1f
		|-> ##3 !periph_in[19]) else $error("tied input not low");

	cover property (cfg_wr_taken_r);
	cover property (cfg_wr_en && map_write_lock);
	cover property ($rose(periph_in[19]));
endmodule

bind rps_top rps_top_assertions #(.NPINS(NPINS)) u_chk (.sys_clk(sys_clk), .rst(rst),
	.map_write_lock(map_write_lock), .cfg_wr_en(cfg_wr_en), .cfg_wr_out(cfg_wr_out),
	.cfg_wr_idx(cfg_wr_idx), .cfg_wr_data(cfg_wr_data), .cfg_wr_done_r(cfg_wr_done_r),
	.cfg_wr_taken_r(cfg_wr_taken_r), .rp_pin_out_r(rp_pin_out_r), .rp_pin_oe_r(rp_pin_oe_r),
	.port_out(port_out), .port_oe(port_oe), .comparator_one_out(comparator_one_out),
	.periph_in(periph_in));

// file: bench/rps_far_model.sv
// peripherals and pin pads around the remappable pin select block
`timescale 1ns/100ps

module rps_far_model
#(
	parameter NPINS = 26
)
(
	// clock
	input  wire             sys_clk,
	// pin pads
	input  wire [NPINS-1:0] pin_lvl,
	input  wire [NPINS-1:0] pin_out,
	input  wire [NPINS-1:0] pin_oe,
	output wire [NPINS-1:0] pin_in,
	// peripheral outputs, bit n feeds output code n
	output reg  [27:0]      src_r
);
	// a driven pad reads back its own level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_lvl);
	// the source pattern shifts one place each cycle so stale routing shows
	initial src_r = 28'h5a3_c96e;
	always @(negedge sys_clk)
		src_r <= {src_r[26:0], ~src_r[27]};
endmodule

// file: bench/test_rps_top.sv
// self-checking bench for the remappable pin select block
`timescale 1ns/100ps
`include "rps_defines.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end

module test_rps_top;
	localparam NP = 26;
	localparam [31:0] ASG = 32'h0c3d_1ffe;
	reg           sys_clk = 0;
	reg           rst = 1;
	reg           map_write_lock = 0;
	reg           cfg_wr_en = 0;
	reg           cfg_wr_out = 0;
	reg  [4:0]    cfg_wr_idx = 0;
	reg  [4:0]    cfg_wr_data = 0;
	reg           cfg_rd_out = 0;
	reg  [4:0]    cfg_rd_idx = 0;
	reg  [NP-1:0] pin_lvl = 0;
	reg  [NP-1:0] port_out = 26'h2aa_aaaa;
	reg  [NP-1:0] port_oe = 26'h155_5555;
	reg  [31:0]   s_q = 0;
	int           n_mismatch = 0;
	int           samples_checked = 0;
	wire [4:0]    cfg_rd_data_r;
	wire          cfg_wr_done_r;
	wire          cfg_wr_taken_r;
	wire [NP-1:0] rp_pin_in;
	wire [NP-1:0] rp_pin_out_r;
	wire [NP-1:0] rp_pin_oe_r;
	wire [27:0]   src;
	wire [29:0]   periph_in;

	rps_top #(.NPINS(NP)) u_dut (.sys_clk, .rst, .map_write_lock, .cfg_wr_en, .cfg_wr_out,
		.cfg_wr_idx, .cfg_wr_data, .cfg_rd_out, .cfg_rd_idx, .cfg_rd_data_r, .cfg_wr_done_r,
		.cfg_wr_taken_r, .rp_pin_in, .rp_pin_out_r, .rp_pin_oe_r, .port_out, .port_oe,
		.comparator_one_out(src[1]), .comparator_two_out(src[2]), .uart_one_tx_out(src[3]),
		.uart_one_rts_out(src[4]), .uart_two_tx_out(src[5]), .uart_two_rts_out(src[6]),
		.spi_one_dout(src[7]), .spi_one_clk_out(src[8]), .spi_one_sel_out(src[9]),
		.spi_two_dout(src[10]), .spi_two_clk_out(src[11]), .spi_two_sel_out(src[12]),
		.can_tx_out(src[16]), .compare_out(src[21:18]), .decoder_one_direction(src[26]),
		.decoder_two_direction(src[27]), .periph_in);
	rps_far_model #(.NPINS(NP)) u_far (.sys_clk(sys_clk), .pin_lvl(pin_lvl),
		.pin_out(rp_pin_out_r), .pin_oe(rp_pin_oe_r), .pin_in(rp_pin_in), .src_r(src));

	initial forever #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) s_q <= {4'h0, src};

	task wr(input o, input [4:0] i, input [4:0] d, input t);
	begin
		@(negedge sys_clk);
		cfg_wr_en = 1;
		cfg_wr_out = o;
		cfg_wr_idx = i;
		cfg_wr_data = d;
		@(negedge sys_clk);
		cfg_wr_en = 0;
		`CHK(cfg_wr_done_r, 1'b1)
		`CHK(cfg_wr_taken_r, t)
	end
	endtask

	task rd(input o, input [4:0] i, input [4:0] e);
	begin
		cfg_rd_out = o;
		cfg_rd_idx = i;
		repeat (2) @(negedge sys_clk);
		`CHK(cfg_rd_data_r, e)
	end
	endtask

	task t_out;
		int c;
	begin
		for (c = 0; c < 32; c++)
		begin
			wr(1, 5'd3, c[4:0], 1'b1);
			rd(1, 5'd3, c[4:0]);
			`CHK(rp_pin_oe_r[3], ASG[c] | port_oe[3])
			`CHK(rp_pin_out_r[3], ASG[c] ? s_q[c] : port_out[3])
		end
		$display("t_out done");
	end
	endtask

	task t_in;
		int i;
		int k;
	begin
		port_oe = 0;
		for (i = 0; i < 30; i++)
			wr(0, i[4:0], i[4:0] % 5'd26, 1'b1);
		for (k = 0; k < 2; k++)
		begin
			pin_lvl = k ? 26'h12b_3c5a : 26'h2d4_c3a5;
			repeat (4) @(negedge sys_clk);
			for (i = 0; i < 30; i++)
				`CHK(periph_in[i], pin_lvl[i % 26])
		end
		wr(0, 5'd19, 5'h1f, 1'b1);
		repeat (3) @(negedge sys_clk);
		`CHK(periph_in[19], 1'b0)
		$display("t_in done");
	end
	endtask

	task t_lock;
	begin
		map_write_lock = 1;
		wr(1, 5'd3, 5'h01, 1'b0);
		rd(1, 5'd3, 5'h1f);
		map_write_lock = 0;
		$display("t_lock done");
	end
	endtask

	task t_bad;
	begin
		wr(0, 5'd0, 5'd26, 1'b0);
		wr(1, 5'd26, 5'h01, 1'b0);
		wr(0, 5'd30, 5'h00, 1'b0);
		rd(0, 5'd0, 5'd0);
		$display("t_bad done");
	end
	endtask

	task finish_test;
	begin
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask

	initial
	begin
		#300000;
		n_mismatch++;
		finish_test;
	end

	initial
	begin
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 0;
		t_out;
		t_in;
		t_lock;
		t_bad;
		finish_test;
	end
endmodule
